// ===== verilog/dai_pkg.sv
package dai_pkg;

  // ==========================================================
  // Timing and widths
  localparam int DAI_INIT_CYCLES = 3072;
  localparam int DAI_INIT_W      = 12;
  localparam int DAI_SAMPLE_W    = 24;
  localparam int DAI_SLOT_W      = 33;
  localparam int DAI_CNT_W       = 6;
  localparam int DAI_LEN_W       = 12;
  localparam int DAI_GAP_SHIFT   = 4;

  // ==========================================================
  // Master clock ratios to the sample rate
  localparam int DAI_NRATIO             = 7;
  localparam int DAI_RATIO [DAI_NRATIO] = '{128, 192, 256, 384, 512, 768, 1152};
  localparam int DAI_RATIO_TOL          = 2;

  // ==========================================================
  // Format field codes
  localparam logic [2:0] DAI_FMT_RJ24  = 3'h0;
  localparam logic [2:0] DAI_FMT_RJ20  = 3'h1;
  localparam logic [2:0] DAI_FMT_RJ18  = 3'h2;
  localparam logic [2:0] DAI_FMT_RJ16  = 3'h3;
  localparam logic [2:0] DAI_FMT_I2S   = 3'h4;
  localparam logic [2:0] DAI_FMT_LJ24  = 3'h5;
  localparam logic [2:0] DAI_FMT_RESET = DAI_FMT_LJ24;

  localparam logic [4:0] DAI_LEN_16 = 5'h10;
  localparam logic [4:0] DAI_LEN_18 = 5'h12;
  localparam logic [4:0] DAI_LEN_20 = 5'h14;
  localparam logic [4:0] DAI_LEN_24 = 5'h18;

  typedef enum logic [1:0] {DAI_FR_RJ, DAI_FR_I2S, DAI_FR_LJ} dai_framing_t;

  typedef struct packed {
    dai_framing_t framing;
    logic [4:0]   len;
  } dai_fmt_t;

  function automatic dai_fmt_t dai_decode_fmt(input logic [2:0] code);
    dai_fmt_t f;
    f = '{DAI_FR_LJ, DAI_LEN_24};
    case (code)
      DAI_FMT_RJ24: f = '{DAI_FR_RJ, DAI_LEN_24};
      DAI_FMT_RJ20: f = '{DAI_FR_RJ, DAI_LEN_20};
      DAI_FMT_RJ18: f = '{DAI_FR_RJ, DAI_LEN_18};
      DAI_FMT_RJ16: f = '{DAI_FR_RJ, DAI_LEN_16};
      DAI_FMT_I2S:  f = '{DAI_FR_I2S, DAI_LEN_24};
      default:      f = '{DAI_FR_LJ, DAI_LEN_24};
    endcase
    return f;
  endfunction

endpackage

// ===== verilog/dai_link_rx.sv
`timescale 1ns/1ps
module dai_link_rx (
  // Link clock and reset
  input  wire logic                         serial_bit_clock_i,
  input  wire logic                         resetn_i,
  // Serial audio pins
  input  wire logic                         word_select_clock_i,
  input  wire logic                         serial_data_i,
  // Hand-over to system domain
  output logic                              req_toggle_o,
  output logic [dai_pkg::DAI_SLOT_W-1:0]    word_o,
  output logic [dai_pkg::DAI_CNT_W-1:0]     count_o,
  output logic                              chan_o
);
  import dai_pkg::*;

  logic                   ws_last_r;
  logic [DAI_SLOT_W-2:0]  shift_r;
  logic [DAI_CNT_W-1:0]   cnt_r;

  // No acknowledge path: the bit clock may stop between slots, so an
  // acknowledge could not cross back in time. The word instead stands
  // for a whole slot; slots shorter than about five master clocks corrupt.

  // ==========================================================
  // Shift register
  always_ff @(posedge serial_bit_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ws_last_r <= 1'b0;
      shift_r   <= '0;
      cnt_r     <= '0;
    end else begin
      ws_last_r <= word_select_clock_i;
      // R06 rising-edge bit capture
      if (word_select_clock_i != ws_last_r) begin
        shift_r <= {{(DAI_SLOT_W-2){1'b0}}, serial_data_i};
        cnt_r   <= 6'h01;
      end else begin
        shift_r <= {shift_r[DAI_SLOT_W-3:0], serial_data_i};
        if (cnt_r != 6'h3f) begin
          cnt_r <= cnt_r + 6'h01;
        end
      end
    end
  end

  // ==========================================================
  // Word hand-over at each word-select edge
  always_ff @(posedge serial_bit_clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_toggle_o <= 1'b0;
      word_o       <= '0;
      count_o      <= '0;
      chan_o       <= 1'b0;
    end else if (word_select_clock_i != ws_last_r) begin
      // R07 transfer slot on edge
      word_o       <= {shift_r, serial_data_i};
      count_o      <= cnt_r;
      chan_o       <= ws_last_r;
      req_toggle_o <= ~req_toggle_o;
    end
  end

endmodule

// ===== verilog/dai_top.sv
`timescale 1ns/1ps
// Notes on behaviour
// R01 - Accept seven master clock ratios to sample rate
// R02 - Source avoids unsupported ratio and rate pairs
// R03 - Initialise for 3072 master clocks after power
// R04 - Hold output at midrail during initialisation
// R05 - Load configuration in next sample period
// R06 - Shift data in on bit clock rise
// R07 - Word select moves slot into holding registers
// R08 - Bit clock runs 32, 48 or 64 fs
// R09 - Link clocks stay synchronous with master clock
// R10 - Suspend on rate change or stopped clocks
// R11 - Resynchronise alone within three sample periods
// R12 - Format field selects RJ, I2S or LJ
// R13 - Pin variant: I2S or 16-bit RJ only
// R14 - Reset default is 24-bit left-justified
// R15 - Samples are two's complement, MSB first
// R16 - I2S: word select low means left
// R17 - LJ and RJ: word select high means left
// R18 - Alignment: I2S delayed, LJ at edge, RJ ends
// R19 - Format field encoding chosen locally
module dai_top #(
  parameter int INIT_CYCLES = dai_pkg::DAI_INIT_CYCLES
) (
  // Master clock and reset
  input  wire logic                           clk_i,
  input  wire logic                           resetn_i,
  // Serial audio link
  input  wire logic                           serial_bit_clock_i,
  input  wire logic                           word_select_clock_i,
  input  wire logic                           serial_data_i,
  // Format control
  input  wire logic                           pin_mode_i,
  input  wire logic                           format_select_pin_i,
  input  wire logic [2:0]                     format_field_i,
  input  wire logic                           format_load_i,
  // Samples
  output logic [dai_pkg::DAI_SAMPLE_W-1:0]    left_sample_o,
  output logic [dai_pkg::DAI_SAMPLE_W-1:0]    right_sample_o,
  output logic                                sample_valid_o,
  // Status
  output logic                                midrail_hold_o,
  output logic                                running_o,
  output logic                                suspended_o,
  output logic [2:0]                          mclk_ratio_o
);
  import dai_pkg::*;

  // ==========================================================
  // Elaboration checks
  if (INIT_CYCLES < 1 || INIT_CYCLES >= (1 << DAI_INIT_W)) begin : g_bad_init
    $error("INIT_CYCLES out of counter range");
  end

  localparam logic [DAI_INIT_W-1:0] INIT_LAST = DAI_INIT_W'(INIT_CYCLES - 1);

  typedef enum logic [1:0] {DAI_ST_INIT, DAI_ST_LOAD, DAI_ST_RUN, DAI_ST_SUSP} dai_state_t;

  // ==========================================================
  // Functions
  function automatic logic [3:0] dai_ratio_match(input logic [DAI_LEN_W-1:0] len);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 0; i < DAI_NRATIO; i++) begin
      if (len + DAI_LEN_W'(DAI_RATIO_TOL) >= DAI_LEN_W'(DAI_RATIO[i]) &&
          len <= DAI_LEN_W'(DAI_RATIO[i] + DAI_RATIO_TOL)) begin
        r = {1'b1, 3'(i)};
      end
    end
    return r;
  endfunction

  function automatic logic dai_near(input logic [DAI_LEN_W-1:0] a,
                                    input logic [DAI_LEN_W-1:0] b);
    logic [DAI_LEN_W-1:0] d;
    d = (a > b) ? (a - b) : (b - a);
    return d <= DAI_LEN_W'(DAI_RATIO_TOL);
  endfunction

  function automatic logic [DAI_SAMPLE_W-1:0] dai_extract(
    input logic [DAI_SLOT_W-1:0] w,
    input logic [DAI_CNT_W-1:0]  n,
    input dai_fmt_t              f
  );
    logic [6:0]              sh;
    logic [DAI_SLOT_W-1:0]   t;
    logic [DAI_SAMPLE_W-1:0] m;
    sh = 7'h01;
    // R18 word alignment per framing
    if (f.framing == DAI_FR_LJ) begin
      sh = {1'b0, n} + 7'h01 - 7'(f.len);
    end else if (f.framing == DAI_FR_I2S) begin
      sh = {1'b0, n} - 7'(f.len);
    end
    // Short slot: take what arrived
    if (sh[6]) begin
      sh = 7'h00;
    end
    t = w >> sh;
    m = t[DAI_SAMPLE_W-1:0] & (DAI_SAMPLE_W'(24'h1 << f.len) - 24'h1);
    // R15 sign kept by MSB alignment
    return DAI_SAMPLE_W'(m << (5'd24 - f.len));
  endfunction

  // ==========================================================
  // Declarations
  dai_state_t               state_r;
  logic [DAI_INIT_W-1:0]    init_cnt_r;
  logic                     req_toggle;
  logic [DAI_SLOT_W-1:0]    link_word;
  logic [DAI_CNT_W-1:0]     link_count;
  logic                     link_chan;
  logic                     req_s1_r;
  logic                     req_s2_r;
  logic                     req_s3_r;
  logic                     req_seen_r;
  logic                     word_evt;
  logic                     fmt_s1_r;
  logic                     fmt_s2_r;
  logic                     fmt_s3_r;
  logic                     fmt_pin_r;
  logic                     strap_done_r;
  logic                     pin_mode_r;
  logic [2:0]               fmt_field_r;
  dai_fmt_t                 want_fmt;
  dai_fmt_t                 act_fmt_r;
  logic                     is_left;
  logic                     frame_end;
  logic [DAI_SAMPLE_W-1:0]  word_val;
  logic [DAI_SAMPLE_W-1:0]  left_hold_r;
  logic [DAI_LEN_W-1:0]     len_cnt_r;
  logic [DAI_LEN_W-1:0]     ref_len_r;
  logic                     ref_valid_r;
  logic [3:0]               ratio_hit;
  logic                     frame_bad;
  logic                     frame_good;
  logic [DAI_LEN_W-1:0]     idle_cnt_r;
  logic [DAI_LEN_W-1:0]     idle_limit;
  logic                     timeout;

  // ==========================================================
  // Link receiver on the bit clock
  dai_link_rx u_link (
    .serial_bit_clock_i  (serial_bit_clock_i),
    .resetn_i            (resetn_i),
    .word_select_clock_i (word_select_clock_i),
    .serial_data_i       (serial_data_i),
    .req_toggle_o        (req_toggle),
    .word_o              (link_word),
    .count_o             (link_count),
    .chan_o              (link_chan)
  );

  // ==========================================================
  // Request crossing into master clock domain
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      req_s1_r   <= 1'b0;
      req_s2_r   <= 1'b0;
      req_s3_r   <= 1'b0;
      req_seen_r <= 1'b0;
    end else begin
      req_s1_r <= req_toggle;
      req_s2_r <= req_s1_r;
      req_s3_r <= req_s2_r;
      if (word_evt) begin
        req_seen_r <= req_s3_r;
      end
    end
  end

  // Link word stays put for a whole slot; req_seen_r stays in this domain
  assign word_evt = (req_s2_r == req_s3_r) && (req_s3_r != req_seen_r);

  // ==========================================================
  // Format selection
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fmt_s1_r  <= 1'b0;
      fmt_s2_r  <= 1'b0;
      fmt_s3_r  <= 1'b0;
      fmt_pin_r <= 1'b0;
    end else begin
      fmt_s1_r <= format_select_pin_i;
      fmt_s2_r <= fmt_s1_r;
      fmt_s3_r <= fmt_s2_r;
      if (fmt_s2_r == fmt_s3_r) begin
        fmt_pin_r <= fmt_s3_r;
      end
    end
  end

  // Variant strap caught once, just after reset release
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      strap_done_r <= 1'b0;
      pin_mode_r   <= 1'b0;
    end else if (!strap_done_r) begin
      strap_done_r <= 1'b1;
      pin_mode_r   <= pin_mode_i;
    end
  end

  // R14 reset format value
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fmt_field_r <= DAI_FMT_RESET;
    end else if (format_load_i) begin
      fmt_field_r <= format_field_i;
    end
  end

  always_comb begin
    // R13 pin picks I2S or RJ16
    if (pin_mode_r) begin
      want_fmt = dai_decode_fmt(fmt_pin_r ? DAI_FMT_RJ16 : DAI_FMT_I2S);
    end else begin
      // R12 R19 field decode
      want_fmt = dai_decode_fmt(fmt_field_r);
    end
  end

  // Switch only on frame boundaries so no frame mixes two formats
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_fmt_r <= dai_decode_fmt(DAI_FMT_RESET);
    end else if (frame_end && state_r != DAI_ST_INIT) begin
      // R05 configuration load
      act_fmt_r <= want_fmt;
    end
  end

  // ==========================================================
  // Channel decode and extraction
  // R16 R17 word-select polarity
  assign is_left   = (act_fmt_r.framing == DAI_FR_I2S) ? !link_chan : link_chan;
  assign frame_end = word_evt && !is_left;
  assign word_val  = dai_extract(link_word, link_count, act_fmt_r);

  // ==========================================================
  // Frame timing monitor
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      len_cnt_r <= '0;
    end else if (frame_end) begin
      len_cnt_r <= 12'h001;
    end else if (len_cnt_r != 12'hfff) begin
      len_cnt_r <= len_cnt_r + 12'h001;
    end
  end

  // R01 ratio match
  assign ratio_hit = dai_ratio_match(len_cnt_r);
  // R10 rate change detect
  assign frame_bad  = frame_end && (!ratio_hit[3] ||
                      (ref_valid_r && !dai_near(len_cnt_r, ref_len_r)));
  assign frame_good = frame_end && ratio_hit[3] && dai_near(len_cnt_r, ref_len_r);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ref_len_r    <= '0;
      ref_valid_r  <= 1'b0;
      mclk_ratio_o <= 3'h0;
    end else if (frame_end) begin
      ref_len_r   <= len_cnt_r;
      ref_valid_r <= (state_r != DAI_ST_LOAD);
      // Ratio stands while running; a bad frame moves it only outside the run state
      if (ratio_hit[3] && (state_r != DAI_ST_RUN || !frame_bad)) begin
        mclk_ratio_o <= ratio_hit[2:0];
      end
    end
  end

  // Gap limit: half a frame plus a sixteenth of a frame
  assign idle_limit = (ref_len_r >> 1) + (ref_len_r >> DAI_GAP_SHIFT);
  assign timeout    = ref_valid_r && (idle_cnt_r > idle_limit);

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      idle_cnt_r <= '0;
    end else if (word_evt) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != 12'hfff) begin
      idle_cnt_r <= idle_cnt_r + 12'h001;
    end
  end

  // ==========================================================
  // Sequencer
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_cnt_r <= '0;
    end else if (state_r == DAI_ST_INIT && init_cnt_r != INIT_LAST) begin
      // R03 init count
      init_cnt_r <= init_cnt_r + 12'h001;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_r <= DAI_ST_INIT;
    end else begin
      case (state_r)
        DAI_ST_INIT: begin
          if (init_cnt_r == INIT_LAST) begin
            state_r <= DAI_ST_LOAD;
          end
        end
        DAI_ST_LOAD: begin
          // R05 one sample period load
          if (frame_end) begin
            state_r <= DAI_ST_RUN;
          end
        end
        DAI_ST_RUN: begin
          // R10 suspend on fault
          if (frame_bad || timeout) begin
            state_r <= DAI_ST_SUSP;
          end
        end
        DAI_ST_SUSP: begin
          // R11 self resync
          if (frame_good) begin
            state_r <= DAI_ST_RUN;
          end
        end
        default: state_r <= DAI_ST_INIT;
      endcase
    end
  end

  // ==========================================================
  // Channel holding and sample output
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      left_hold_r    <= '0;
      left_sample_o  <= '0;
      right_sample_o <= '0;
      sample_valid_o <= 1'b0;
    end else begin
      sample_valid_o <= 1'b0;
      if (state_r != DAI_ST_RUN) begin
        // Zero code is midrail for two's complement data
        left_sample_o  <= '0;
        right_sample_o <= '0;
      end
      // R07 holding registers
      if (word_evt && is_left) begin
        left_hold_r <= word_val;
      end
      if (frame_end && state_r == DAI_ST_RUN && !frame_bad && !timeout) begin
        left_sample_o  <= left_hold_r;
        right_sample_o <= word_val;
        sample_valid_o <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Status
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      midrail_hold_o <= 1'b1;
      running_o      <= 1'b0;
      suspended_o    <= 1'b0;
    end else begin
      // R04 midrail until running
      midrail_hold_o <= (state_r != DAI_ST_RUN);
      running_o      <= (state_r == DAI_ST_RUN);
      suspended_o    <= (state_r == DAI_ST_SUSP);
    end
  end

endmodule

// ===== bench/dai_top_properties.sv
`timescale 1ns/1ps
module dai_top_properties #(
  parameter int INIT_CYCLES = dai_pkg::DAI_INIT_CYCLES
) (
  // Clock and reset
  input wire logic                             clk_i,
  input wire logic                             resetn_i,
  // Watched outputs
  input wire logic [dai_pkg::DAI_SAMPLE_W-1:0] left_sample_o,
  input wire logic [dai_pkg::DAI_SAMPLE_W-1:0] right_sample_o,
  input wire logic                             sample_valid_o,
  input wire logic                             midrail_hold_o,
  input wire logic                             running_o,
  input wire logic                             suspended_o,
  input wire logic [2:0]                       mclk_ratio_o
);
  import dai_pkg::*;

  // ==========
  // Cycles since reset release, saturating at the init length
  logic [12:0] init_cnt_r;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      init_cnt_r <= 13'h0;
    end else if (init_cnt_r < 13'(INIT_CYCLES)) begin
      init_cnt_r <= init_cnt_r + 13'h1;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  // ==========
  // Properties
  AST_INIT_HOLD: assert property (
    init_cnt_r < 13'(INIT_CYCLES) |-> midrail_hold_o && !running_o)
    else $error("Output active during init");
  AST_RESET_STATE: assert property (
    !$past(resetn_i) |-> midrail_hold_o && !running_o && !suspended_o && !sample_valid_o)
    else $error("Wrong state after reset");
  AST_RUN_CLEAR: assert property (
    running_o |-> !midrail_hold_o && !suspended_o)
    else $error("Midrail held while running");
  AST_SUSP_HOLD: assert property (
    suspended_o |-> midrail_hold_o && !running_o)
    else $error("Suspended without midrail hold");
  AST_LEAVE_RUN: assert property (
    $fell(running_o) |-> (midrail_hold_o && !running_o) [*3])
    else $error("Run left and re-entered too soon");
  AST_VALID_PULSE: assert property (
    sample_valid_o |=> !sample_valid_o)
    else $error("Valid longer than one cycle");
  AST_VALID_RUN: assert property (
    sample_valid_o |-> running_o)
    else $error("Valid outside run");
  AST_SAMPLE_HOLD: assert property (
    running_o && $past(running_o) && !sample_valid_o
      |-> $stable(left_sample_o) && $stable(right_sample_o))
    else $error("Samples moved without valid");
  AST_IDLE_ZERO: assert property (
    !running_o && !$past(running_o) |-> left_sample_o == '0 && right_sample_o == '0)
    else $error("Samples nonzero outside run");
  AST_RATIO_HOLD: assert property (
    running_o && $past(running_o) |-> $stable(mclk_ratio_o) && mclk_ratio_o <= 3'h6)
    else $error("Ratio index unstable or out of range");
endmodule

bind dai_top dai_top_properties #(
  .INIT_CYCLES(INIT_CYCLES)
) i_dai_top_properties (
  .clk_i          (clk_i),
  .resetn_i       (resetn_i),
  .left_sample_o  (left_sample_o),
  .right_sample_o (right_sample_o),
  .sample_valid_o (sample_valid_o),
  .midrail_hold_o (midrail_hold_o),
  .running_o      (running_o),
  .suspended_o    (suspended_o),
  .mclk_ratio_o   (mclk_ratio_o)
);

// ===== bench/dai_src_model.sv
`timescale 1ns/1ps
module dai_src_model (
  // Master clock and control
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [2:0]  code_i,
  input  wire logic [10:0] half_i,
  input  wire logic [23:0] left_i,
  input  wire logic [23:0] right_i,
  // Serial link
  output logic             serial_bit_clock_o,
  output logic             word_select_clock_o,
  output logic             serial_data_o
);
  logic [31:0] slot;
  logic [4:0]  len;
  logic        i2s;
  logic [23:0] v;

  // ==========
  // Bursts of 32 bits per slot; link clock idles low between them
  initial begin
    serial_bit_clock_o  = 1'b0;
    word_select_clock_o = 1'b0;
    serial_data_o       = 1'b0;
    forever begin
      while (run_i !== 1'b1) @(posedge clk_i);
      for (int ch = 0; ch < 2; ch++) begin
        v   = ch ? right_i : left_i;
        i2s = (code_i == 3'h4);
        len = (code_i == 3'h1) ? 5'h14 : (code_i == 3'h2) ? 5'h12 :
              (code_i == 3'h3) ? 5'h10 : 5'h18;
        if (i2s) begin
          slot = {~v[23], v, 7'h2b};
        end else if (code_i > 3'h4) begin
          slot = {v, 8'h5a};
        end else begin
          slot = (32'hffffffff << len) | 32'(v >> (24 - len));
        end
        #37;
        for (int b = 31; b >= 0; b--) begin
          word_select_clock_o = (ch == 0) ^ i2s;
          serial_data_o       = slot[b];
          #6 serial_bit_clock_o = 1'b1;
          #6 serial_bit_clock_o = 1'b0;
        end
        serial_data_o = ~serial_data_o;
        repeat (half_i - 4) @(posedge clk_i);
      end
    end
  end
endmodule

// ===== bench/tb_top.sv
`timescale 1ns/1ps
`define CHECK(got, exp) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
  end \
end
module tb_top;
  import dai_pkg::*;
  localparam int INIT = 16;

  typedef struct {
    logic [2:0]  code;
    logic [23:0] l;
    logic [23:0] r;
    logic [23:0] el;
    logic [23:0] er;
  } dai_row_t;

  // Row i runs at ratio index i
  dai_row_t rows [7] = '{
    '{3'h0, 24'h812345, 24'h7fedcb, 24'h812345, 24'h7fedcb},
    '{3'h1, 24'h13579b, 24'hf0f0f0, 24'h135790, 24'hf0f0f0},
    '{3'h2, 24'hc00003, 24'h2aaaaa, 24'hc00000, 24'h2aaa80},
    '{3'h3, 24'h800000, 24'h7fffff, 24'h800000, 24'h7fff00},
    '{3'h4, 24'h9abcde, 24'h123456, 24'h9abcde, 24'h123456},
    '{3'h6, 24'hffffff, 24'h000001, 24'hffffff, 24'h000001},
    '{3'h7, 24'h5a5a5a, 24'ha5a5a5, 24'h5a5a5a, 24'ha5a5a5}
  };

  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        pin_mode_i = 1'b0;
  logic        format_select_pin_i = 1'b0;
  logic [2:0]  format_field_i = 3'h0;
  logic        format_load_i = 1'b0;
  logic        run = 1'b1;
  logic [2:0]  code = 3'h5;
  logic [10:0] half = 11'h40;
  logic [23:0] lval = 24'h876543;
  logic [23:0] rval = 24'h0abcde;
  logic        bclk, ws, sd;
  logic [23:0] left_sample_o, right_sample_o;
  logic        sample_valid_o, midrail_hold_o, running_o, suspended_o;
  logic [2:0]  mclk_ratio_o;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cyc;

  always #50 clk_i = ~clk_i;

  dai_top #(
    .INIT_CYCLES(INIT)
  ) i_dai_top (
    .clk_i               (clk_i),
    .resetn_i            (resetn_i),
    .serial_bit_clock_i  (bclk),
    .word_select_clock_i (ws),
    .serial_data_i       (sd),
    .pin_mode_i          (pin_mode_i),
    .format_select_pin_i (format_select_pin_i),
    .format_field_i      (format_field_i),
    .format_load_i       (format_load_i),
    .left_sample_o       (left_sample_o),
    .right_sample_o      (right_sample_o),
    .sample_valid_o      (sample_valid_o),
    .midrail_hold_o      (midrail_hold_o),
    .running_o           (running_o),
    .suspended_o         (suspended_o),
    .mclk_ratio_o        (mclk_ratio_o)
  );

  dai_src_model i_dai_src_model (
    .clk_i               (clk_i),
    .run_i               (run),
    .code_i              (code),
    .half_i              (half),
    .left_i              (lval),
    .right_i             (rval),
    .serial_bit_clock_o  (bclk),
    .word_select_clock_o (ws),
    .serial_data_o       (sd)
  );

  task automatic conclude();
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask

  // Bounded wait for running (sel 0) or suspended (sel 1)
  task automatic wait_on(input logic sel, input int bound);
    for (cyc = 1; cyc <= bound; cyc++) begin
      tick(1);
      if ((sel ? suspended_o : running_o) === 1'b1) return;
    end
    n_mismatch++;
    conclude();
  endtask

  task automatic wait_valid(input int n);
    int seen;
    seen = 0;
    for (int k = 0; k < 3000 && seen < n; k++) begin
      tick(1);
      if (sample_valid_o === 1'b1) seen++;
    end
    if (seen < n) begin
      n_mismatch++;
      conclude();
    end
  endtask

  // Stop the link long enough to suspend, reload, resume
  task automatic restart(input logic [2:0] c, input logic [10:0] h,
                         input logic [23:0] l, r, el, er);
    run = 1'b0;
    tick(2200);
    `CHECK(suspended_o, 1'b1)
    format_field_i = c;
    format_load_i  = 1'b1;
    tick(1);
    format_load_i  = 1'b0;
    code = c;
    half = h;
    lval = l;
    rval = r;
    run  = 1'b1;
    wait_on(1'b0, 6 * h + 16);
    wait_valid(2);
    `CHECK(left_sample_o, el)
    `CHECK(right_sample_o, er)
  endtask

  initial begin
    tick(2);
    `CHECK({midrail_hold_o, running_o, suspended_o, sample_valid_o}, 4'h8)
    `CHECK(left_sample_o, 24'h0)
    resetn_i = 1'b1;
    wait_on(1'b0, INIT + 150);
    `CHECK(cyc > INIT, 1'b1)
    wait_valid(2);
    `CHECK(left_sample_o, 24'h876543)
    `CHECK(right_sample_o, 24'h0abcde)
    for (int i = 0; i < 7; i++) begin
      restart(rows[i].code, 11'(DAI_RATIO[i] / 2), rows[i].l, rows[i].r,
              rows[i].el, rows[i].er);
      `CHECK(mclk_ratio_o, 3'(i))
    end
    // Rate change with the link still running
    half = 11'h40;
    wait_on(1'b1, 1800);
    wait_on(1'b0, 400);
    `CHECK(mclk_ratio_o, 3'h0)
    // Reset mid-run into the pin-controlled variant
    resetn_i            = 1'b0;
    pin_mode_i          = 1'b1;
    format_select_pin_i = 1'b1;
    code                = 3'h3;
    lval                = 24'h8001ff;
    rval                = 24'h7ffe00;
    tick(2);
    `CHECK({midrail_hold_o, running_o, left_sample_o}, 26'h2000000)
    resetn_i       = 1'b1;
    tick(1);
    format_field_i = 3'h5;
    format_load_i  = 1'b1;
    tick(1);
    format_load_i  = 1'b0;
    wait_on(1'b0, INIT + 150);
    wait_valid(2);
    `CHECK(left_sample_o, 24'h800100)
    `CHECK(right_sample_o, 24'h7ffe00)
    format_select_pin_i = 1'b0;
    restart(3'h4, 11'h40, 24'h00ff01, 24'hff00fe, 24'h00ff01, 24'hff00fe);
    conclude();
  end
endmodule
